// file: hdl/stw_pkg.sv
// stw_pkg: register offsets, field positions and reset values of the system timers
// assumes an 8-bit special-function register port with byte addresses
`default_nettype none
package stw_pkg;
  localparam logic [7:0] ADDR_SEC    = 8'hf9;
  localparam logic [7:0] ADDR_MS     = 8'hfa;
  localparam logic [7:0] ADDR_US     = 8'hfb;
  localparam logic [7:0] ADDR_MSL    = 8'hfc;
  localparam logic [7:0] ADDR_MSH    = 8'hfd;
  localparam logic [7:0] ADDR_TENTH  = 8'hfe;
  localparam logic [7:0] ADDR_WDOG   = 8'hff;
  localparam logic [6:0] RST_SEC     = 7'h7f;
  localparam logic [6:0] RST_MS      = 7'h7f;
  localparam logic [5:0] RST_US      = 6'h03;
  localparam logic [7:0] RST_MSL     = 8'h9f;
  localparam logic [7:0] RST_MSH     = 8'h0f;
  localparam logic [6:0] RST_TENTH   = 7'h63;
  localparam logic [7:0] RST_WDOG    = 8'h00;
  localparam int         BIT_LOAD    = 7;
  localparam int         BIT_ARM     = 7;
  localparam int         BIT_DISARM  = 6;
  localparam int         BIT_KICK    = 5;
  localparam int         PERIOD_W    = 5;
  localparam int         SCALE       = 256;
endpackage : stw_pkg
`default_nettype wire

// file: hdl/stw_divider.sv
// stw_divider: reloadable down counter emitting a tick at terminal count
// assumes the caller gates it with its enable and advance inputs
`default_nettype none
module stw_divider #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         ce,
  // control
  input  wire logic         advance,
  input  wire logic         load_now,
  input  wire logic [W-1:0] reload,
  input  wire logic [W-1:0] rst_val,
  // result
  output logic              tick
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic         tick_ff;
  logic         nxt_tick;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_tick = 1'b0;
    if (load_now) begin
      nxt_cnt = reload;
    end else if (advance) begin
      if (cnt_ff == '0) begin
        nxt_cnt  = reload;  // [RULE_19]
        nxt_tick = 1'b1;    // [RULE_19]
      end else begin
        nxt_cnt = cnt_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule : stw_divider
`default_nettype wire

// file: hdl/stw_timers.sv
// stw_timers: system tick dividers, interval interrupts and watchdog
// assumes a same-clock processor register port with one-cycle strobes
//
// Summary of operation
// [RULE_01] millisecond tick divides clock by high*256 + low + 1
// [RULE_02] tenth-second tick divides millisecond tick by divider plus one
// [RULE_03] seconds interrupt every count+1 tenth-second ticks
// [RULE_04] reading seconds count clears its pending interrupt; software clears aux flag
// [RULE_05] seconds interrupt status visible on enable and poll views
// [RULE_06] millisecond interrupt every count+1 millisecond ticks
// [RULE_07] reading millisecond count clears its interrupt; software clears aux flag
// [RULE_08] load-now 0 defers new count until expiry; bit reads zero
// [RULE_09] load-now 1 loads the counter right after the write
// [RULE_10] microsecond tick divides clock by divider plus one
// [RULE_11] write 1 then 0 to arm bit enables watchdog counting
// [RULE_12] write 1 then 0 to disarm bit stops watchdog counting
// [RULE_13] write 1 then 0 to kick bit restarts watchdog from zero
// [RULE_14] armed watchdog expires after period+1 to period+2 tenth ticks
// [RULE_15] watchdog power-down holds the watchdog stopped
// [RULE_16] timer power-down holds the whole tick chain stopped
// [RULE_17] watchdog interrupt forwarded only while its enable is set
// [RULE_18] one-cycle expiry pulse on watchdog timeout
// [RULE_19] dividers reload and pulse one cycle at terminal count
`default_nettype none
module stw_timers (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       ce,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // power-down and watchdog interrupt enable controls
  input  wire logic       systimer_powerdown,
  input  wire logic       watchdog_powerdown,
  input  wire logic       watchdog_irq_enable,
  // ticks and events
  output logic            us_tick,
  output logic            ms_tick,
  output logic            tenth_tick,
  output logic            sec_irq_pending,
  output logic            ms_irq_pending,
  output logic            watchdog_expired,
  output logic            watchdog_irq
);
  typedef struct packed {
    logic [6:0] sec_val;
    logic [6:0] ms_val;
    logic [5:0] us_val;
    logic [7:0] msl;
    logic [7:0] msh;
    logic [6:0] tenth_val;
    logic [7:0] wdog_ctl;
    logic [6:0] sec_cnt;
    logic [6:0] ms_cnt;
    logic       sec_pend;
    logic       ms_pend;
    logic       wd_run;
    logic [5:0] wd_cnt;
    logic       wd_exp;
    logic [7:0] rdata;
  } stw_state_s;

  stw_state_s st_ff;
  stw_state_s nxt_st;

  logic       wr_sec;
  logic       wr_ms;
  logic       wr_tenth;
  logic       load_bit;
  logic       run;
  logic       ms_raw;
  logic       us_raw;
  logic       tenth_raw;
  logic [15:0] ms_div;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction : hit

  assign load_bit = reg_wdata[stw_pkg::BIT_LOAD];
  assign wr_sec   = reg_wr && hit(reg_addr, stw_pkg::ADDR_SEC);
  assign wr_ms    = reg_wr && hit(reg_addr, stw_pkg::ADDR_MS);
  assign wr_tenth = reg_wr && hit(reg_addr, stw_pkg::ADDR_TENTH);
  assign run      = !systimer_powerdown;  // [RULE_16]
  assign ms_div   = 16'(st_ff.msh) * 16'(stw_pkg::SCALE) + 16'(st_ff.msl);  // [RULE_01]

  stw_divider #(.W(6)) u_us (
    .mclk     (mclk),
    .rstn     (rstn),
    .ce       (ce),
    .advance  (run),
    .load_now (1'b0),
    .reload   (st_ff.us_val),
    .rst_val  (stw_pkg::RST_US),
    .tick     (us_raw)               // [RULE_10]
  );

  stw_divider #(.W(16)) u_ms (
    .mclk     (mclk),
    .rstn     (rstn),
    .ce       (ce),
    .advance  (run),
    .load_now (1'b0),
    .reload   (ms_div),
    .rst_val  ({stw_pkg::RST_MSH, stw_pkg::RST_MSL}),
    .tick     (ms_raw)               // [RULE_01]
  );

  stw_divider #(.W(7)) u_tenth (
    .mclk     (mclk),
    .rstn     (rstn),
    .ce       (ce),
    .advance  (run && ms_raw),       // [RULE_02]
    .load_now (wr_tenth && load_bit),  // [RULE_09]
    .reload   (wr_tenth ? reg_wdata[6:0] : st_ff.tenth_val),
    .rst_val  (stw_pkg::RST_TENTH),
    .tick     (tenth_raw)
  );

  assign us_tick    = us_raw;
  assign ms_tick    = ms_raw;
  assign tenth_tick = tenth_raw;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.wd_exp = 1'b0;
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        stw_pkg::ADDR_SEC: begin
          nxt_st.sec_val = reg_wdata[6:0];
          if (load_bit) nxt_st.sec_cnt = reg_wdata[6:0];  // [RULE_09]
        end
        stw_pkg::ADDR_MS: begin
          nxt_st.ms_val = reg_wdata[6:0];
          if (load_bit) nxt_st.ms_cnt = reg_wdata[6:0];   // [RULE_09]
        end
        stw_pkg::ADDR_US:    nxt_st.us_val    = reg_wdata[5:0];
        stw_pkg::ADDR_MSL:   nxt_st.msl       = reg_wdata;
        stw_pkg::ADDR_MSH:   nxt_st.msh       = reg_wdata;
        stw_pkg::ADDR_TENTH: nxt_st.tenth_val = reg_wdata[6:0];
        stw_pkg::ADDR_WDOG: begin
          nxt_st.wdog_ctl = reg_wdata;
          // falling edge of each strobe bit completes its sequence
          if (st_ff.wdog_ctl[stw_pkg::BIT_ARM] && !reg_wdata[stw_pkg::BIT_ARM]) begin
            nxt_st.wd_run = 1'b1;  // [RULE_11]
            nxt_st.wd_cnt = '0;
          end
          if (st_ff.wdog_ctl[stw_pkg::BIT_DISARM] && !reg_wdata[stw_pkg::BIT_DISARM]) begin
            nxt_st.wd_run = 1'b0;  // [RULE_12]
          end
          if (st_ff.wdog_ctl[stw_pkg::BIT_KICK] && !reg_wdata[stw_pkg::BIT_KICK]) begin
            nxt_st.wd_cnt = '0;    // [RULE_13]
          end
        end
        default: begin
        end
      endcase
    end
    // reads clear pending interrupts
    if (reg_rd && hit(reg_addr, stw_pkg::ADDR_SEC)) nxt_st.sec_pend = 1'b0;  // [RULE_04]
    if (reg_rd && hit(reg_addr, stw_pkg::ADDR_MS))  nxt_st.ms_pend  = 1'b0;  // [RULE_07]
    // interval counters, deferred reload uses held value
    if (run && ms_raw && !(wr_ms && load_bit)) begin
      if (st_ff.ms_cnt == '0) begin
        nxt_st.ms_cnt  = wr_ms ? reg_wdata[6:0] : st_ff.ms_val;  // [RULE_08]
        nxt_st.ms_pend = 1'b1;  // [RULE_06] set wins over read clear
      end else begin
        nxt_st.ms_cnt = st_ff.ms_cnt - 7'd1;
      end
    end
    if (run && tenth_raw && !(wr_sec && load_bit)) begin
      if (st_ff.sec_cnt == '0) begin
        nxt_st.sec_cnt  = wr_sec ? reg_wdata[6:0] : st_ff.sec_val;  // [RULE_08]
        nxt_st.sec_pend = 1'b1;  // [RULE_03]
      end else begin
        nxt_st.sec_cnt = st_ff.sec_cnt - 7'd1;
      end
    end
    // watchdog counts tenth ticks
    if (st_ff.wd_run && !watchdog_powerdown && run && tenth_raw) begin  // [RULE_15]
      if (st_ff.wd_cnt >= 6'(st_ff.wdog_ctl[stw_pkg::PERIOD_W-1:0]) + 6'd1) begin
        nxt_st.wd_exp = 1'b1;  // [RULE_14] [RULE_18]
        nxt_st.wd_cnt = '0;
      end else begin
        nxt_st.wd_cnt = st_ff.wd_cnt + 6'd1;
      end
    end
    // read data, load bit reads zero
    case (reg_addr)
      stw_pkg::ADDR_SEC:   nxt_st.rdata = {1'b0, st_ff.sec_val};  // [RULE_08]
      stw_pkg::ADDR_MS:    nxt_st.rdata = {1'b0, st_ff.ms_val};
      stw_pkg::ADDR_US:    nxt_st.rdata = {2'b00, st_ff.us_val};
      stw_pkg::ADDR_MSL:   nxt_st.rdata = st_ff.msl;
      stw_pkg::ADDR_MSH:   nxt_st.rdata = st_ff.msh;
      stw_pkg::ADDR_TENTH: nxt_st.rdata = {1'b0, st_ff.tenth_val};
      stw_pkg::ADDR_WDOG:  nxt_st.rdata = st_ff.wdog_ctl;
      default:             nxt_st.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_ff           <= '0;
      st_ff.sec_val   <= stw_pkg::RST_SEC;
      st_ff.ms_val    <= stw_pkg::RST_MS;
      st_ff.us_val    <= stw_pkg::RST_US;
      st_ff.msl       <= stw_pkg::RST_MSL;
      st_ff.msh       <= stw_pkg::RST_MSH;
      st_ff.tenth_val <= stw_pkg::RST_TENTH;
      st_ff.wdog_ctl  <= stw_pkg::RST_WDOG;
      st_ff.sec_cnt   <= stw_pkg::RST_SEC;
      st_ff.ms_cnt    <= stw_pkg::RST_MS;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata        = st_ff.rdata;
  assign sec_irq_pending  = st_ff.sec_pend;  // [RULE_05]
  assign ms_irq_pending   = st_ff.ms_pend;
  assign watchdog_expired = st_ff.wd_exp;
  assign watchdog_irq     = st_ff.wd_exp && watchdog_irq_enable;  // [RULE_17]
endmodule : stw_timers
`default_nettype wire

// file: test/stw_timers_properties.sv
// stw_timers_properties: port checker for the system timers
// assumes ce high and the stw_pkg register map
`default_nettype none
module stw_timers_properties (
  // clock, reset and register port
  input wire logic       mclk, rstn, ce, reg_wr, reg_rd,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  // controls
  input wire logic       systimer_powerdown, watchdog_powerdown, watchdog_irq_enable,
  // ticks and events
  input wire logic       us_tick, ms_tick, tenth_tick, sec_irq_pending,
  input wire logic       ms_irq_pending, watchdog_expired, watchdog_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_rd_ms;
    reg_rd && reg_addr == stw_pkg::ADDR_MS && !ms_tick ##1 !ms_tick;
  endsequence
  sequence s_rd_sec;
    reg_rd && reg_addr == stw_pkg::ADDR_SEC && !tenth_tick ##1 !tenth_tick;
  endsequence
  chk_irq_gate: assert property (
    watchdog_irq == (watchdog_expired && watchdog_irq_enable)) else $error("irq gate");
  chk_expiry_pulse: assert property (
    watchdog_expired |=> !watchdog_expired) else $error("expiry pulse long");
  chk_ms_pulse: assert property (ms_tick |=> !ms_tick) else $error("ms tick long");
  chk_us_pulse: assert property (us_tick |=> !us_tick) else $error("us tick long");
  chk_wdog_stop: assert property (
    watchdog_powerdown [*2] |-> !watchdog_expired) else $error("watchdog ran");
  chk_chain_stop: assert property (
    systimer_powerdown [*2] |-> !ms_tick && !us_tick) else $error("chain ran");
  chk_ms_clear: assert property (s_rd_ms |-> !ms_irq_pending) else $error("ms clr");
  chk_sec_clear: assert property (s_rd_sec |-> !sec_irq_pending) else $error("sec clr");
  chk_bit7_zero: assert property (
    reg_addr inside {8'hf9, 8'hfa, 8'hfe} |=> !reg_rdata[7]) else $error("bit7 set");
  chk_unmapped_zero: assert property (
    reg_addr < 8'hf9 |=> reg_rdata == 8'h00) else $error("unmapped read");
endmodule : stw_timers_properties
bind stw_timers stw_timers_properties u_chk (.*);
`default_nettype wire

// file: test/stw_timers_tb_top.sv
// stw_timers_tb_top: directed scenarios for the system timers
// assumes the design and its bound checker are compiled first
`default_nettype none
module stw_timers_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, rstn, reg_wr, reg_rd, st_pd, wd_pd, wd_ie;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic       us_t, ms_t, te_t, sec_p, ms_p, wd_exp, wd_irq;
  logic [5:0] ev;
  int         mismatches, n_checks, cyc, n, n_exp, n_ms;
  logic [7:0] rv [7] = '{8'h7f, 8'h7f, 8'h03, 8'h9f, 8'h0f, 8'h63, 8'h00};
  assign ev = {wd_exp, sec_p, ms_p, te_t, ms_t, us_t};
  stw_timers u_dut (.mclk(mclk), .rstn(rstn), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .systimer_powerdown(st_pd), .watchdog_powerdown(wd_pd), .watchdog_irq_enable(wd_ie),
    .us_tick(us_t), .ms_tick(ms_t), .tenth_tick(te_t), .sec_irq_pending(sec_p),
    .ms_irq_pending(ms_p), .watchdog_expired(wd_exp), .watchdog_irq(wd_irq));
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    n_exp <= n_exp + int'(wd_exp);
    n_ms <= n_ms + int'(ms_t);
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step(input int k = 1);
    repeat (k) @(posedge mclk);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1;
    @(posedge mclk);
    reg_wr <= 0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge mclk);
    reg_rd <= 0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic gap(input int b);
    while (ev[b] !== 1'b1) step();
    n = 0;
    do begin
      step();
      n++;
    end while (ev[b] !== 1'b1 && n < 3000);
  endtask : gap
  task automatic t_regs();
    for (int i = 0; i < 7; i++) begin
      rd(8'hf9 + 8'(i));
      check("reset value", d, rv[i]);
    end
    rd(8'hf8);
    check("unmapped", d, 0);
    wr(8'hfa, 8'h85);
    rd(8'hfa);
    check("load bit", d, 8'h05);
    $display("test regs done");
  endtask : t_regs
  task automatic t_ticks();
    wr(8'hfb, 8'h02);
    gap(0);
    gap(0);
    check("us period", n, 3);
    wr(8'hfd, 8'h01);
    wr(8'hfc, 8'h02);
    gap(1);
    gap(1);
    check("ms period", n, 259);
    wr(8'hfd, 8'h00);
    wr(8'hfc, 8'h03);
    wr(8'hfe, 8'h81);
    gap(1);
    gap(2);
    gap(2);
    check("tenth period", n, 8);
    step(1);
    wr(8'hfe, 8'h03);
    n = 0;
    while (!te_t && n < 99) begin
      step();
      n++;
    end
    check("deferred", n <= 8, 1);
    gap(2);
    check("tenth new", n, 16);
    step(1);
    wr(8'hfe, 8'h81);
    n = 0;
    while (!te_t && n < 99) begin
      step();
      n++;
    end
    check("immediate", n > 2 && n <= 8, 1);
    st_pd <= 1;
    step(3);
    n = n_ms;
    step(50);
    check("chain stop", n_ms, n);
    st_pd <= 0;
    $display("test ticks done");
  endtask : t_ticks
  task automatic t_irq(input int b, input logic [7:0] a, input int exp);
    rd(a);
    while (ev[b] !== 1'b1) step();
    rd(a);
    check("pend clear", ev[b], 0);
    n = 2;
    while (ev[b] !== 1'b1 && n < 3000) begin
      step();
      n++;
    end
    check("irq interval", n, exp);
    $display("test irq done");
  endtask : t_irq
  task automatic t_wdog();
    wr(8'hff, 8'h81);
    n = n_exp;
    step(60);
    check("half arm", n_exp, n);
    wr(8'hff, 8'h01);
    n = 0;
    while (!wd_exp && n < 99) begin
      step();
      n++;
    end
    check("expiry window", n >= 16 && n <= 27, 1);
    check("irq fwd", wd_irq, 1);
    step();
    check("expiry pulse", wd_exp, 0);
    n = n_exp;
    repeat (8) begin
      wr(8'hff, 8'h21);
      wr(8'hff, 8'h01);
      step(8);
    end
    check("kicked", n_exp, n);
    wd_pd <= 1;
    step(80);
    check("powered down", n_exp, n);
    wd_pd <= 0;
    wr(8'hff, 8'h41);
    wr(8'hff, 8'h01);
    step(80);
    check("disarmed", n_exp, n);
    $display("test watchdog done");
  endtask : t_wdog
  initial begin
    {rstn, reg_wr, reg_rd, st_pd, wd_pd, wd_ie, reg_addr, reg_wdata} = '0;
    {cyc, mismatches, n_checks, n_exp, n_ms} = '0;
    repeat (4) @(posedge mclk);
    rstn <= 1;
    wd_ie <= 1;
    t_regs();
    t_ticks();
    wr(8'hfa, 8'h82);
    t_irq(3, 8'hfa, 12);
    wr(8'hf9, 8'h81);
    t_irq(4, 8'hf9, 16);
    t_wdog();
    tally_and_finish();
  end
endmodule : stw_timers_tb_top
`default_nettype wire
